// ===== poe_irq_pkg.sv
// Shared constants for the port event and interrupt logic
package poe_irq_pkg;

   // Register offsets on the management bus
   localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h00;
   localparam logic [7:0] ADDR_GATE_MASK = 8'h01;
   localparam logic [7:0] ADDR_POWER = 8'h02;
   localparam logic [7:0] ADDR_POWER_CLR = 8'h03;
   localparam logic [7:0] ADDR_PROBE = 8'h04;
   localparam logic [7:0] ADDR_PROBE_CLR = 8'h05;
   localparam logic [7:0] ADDR_FAULT = 8'h06;
   localparam logic [7:0] ADDR_FAULT_CLR = 8'h07;
   localparam logic [7:0] ADDR_START = 8'h08;
   localparam logic [7:0] ADDR_START_CLR = 8'h09;
   localparam logic [7:0] ADDR_SUPPLY = 8'h0A;
   localparam logic [7:0] ADDR_SUPPLY_CLR = 8'h0B;

   // Event groups, index order of the flag banks
   localparam int NUM_GROUPS = 5;
   localparam int G_POWER = 0;
   localparam int G_PROBE = 1;
   localparam int G_FAULT = 2;
   localparam int G_START = 3;
   localparam int G_SUPPLY = 4;
   localparam logic [4:0][7:0] CLEAR_ADDR = {ADDR_SUPPLY_CLR,
      ADDR_START_CLR, ADDR_FAULT_CLR, ADDR_PROBE_CLR, ADDR_POWER_CLR};

   // Summary and mask bit positions
   localparam int BIT_SUPPLY = 7;
   localparam int BIT_START = 6;
   localparam int BIT_OVERCURRENT = 5;
   localparam int BIT_CLASS = 4;
   localparam int BIT_DETECT = 3;
   localparam int BIT_UNPLUG = 2;
   localparam int BIT_POWER_GOOD = 1;
   localparam int BIT_POWER_ON = 0;

   // Supply flag bit positions
   localparam int SUP_THERMAL = 7;
   localparam int SUP_LOGIC_UV = 5;
   localparam int SUP_PORT_UV = 4;
   localparam int SUP_SINE = 1;

   // Reset values
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET_FIXED = 8'h80;
   localparam logic [7:0] MASK_STRAP_BITS = 8'h64;
   localparam logic [7:0] SUPPLY_POR_BASE = 8'h22;
   localparam logic [7:0] SUPPLY_POR_LATE = 8'h10;
   localparam logic [7:0] POINTER_RESET = 8'h00;

   // Link framing
   localparam logic [2:0] SLAVE_ADDR_HIGH = 3'h2;
   localparam logic [3:0] BYTE_FULL = 4'h8;
   localparam logic [3:0] TX_LAST_BIT = 4'h7;

endpackage

// ===== flag_bank_if.sv
// Connection between the register logic and one sticky flag bank
`timescale 1ns/100ps
interface flag_bank_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] set;
   logic clear;
   logic [WIDTH-1:0] por_value;
   logic [WIDTH-1:0] flags;
   modport bank(input set, input clear, input por_value, output flags);
   modport user(output set, output clear, output por_value, input flags);
endinterface

// ===== pin_sync.sv
// Two-stage synchroniser for pins from outside the core clock domain
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,           // Core clock
   input wire logic clk_en,             // Freezes state while low
   input wire logic [WIDTH-1:0] d,      // Asynchronous pin levels
   output logic [WIDTH-1:0] q           // Synchronised levels
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } state_s;

   state_s r;
   state_s next_r;

   // First stage feeds only the second
   always_comb begin
      next_r = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   // Data path only, no reset needed
   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         r <= next_r;
      end
   end

   assign q = r.s2;
endmodule

// ===== sticky_flags.sv
// Sticky event flag bank with clear and power-on value
`timescale 1ns/100ps
module sticky_flags (
   input wire logic core_clk,           // Core clock
   input wire logic reset,              // Synchronous reset, high
   input wire logic clk_en,             // Freezes state while low
   flag_bank_if.bank bank               // Set, clear and flag view
);
   typedef struct packed {
      logic [7:0] flags;
   } state_s;

   state_s q;
   state_s next_q;

   // Set wins over a clear in the same cycle
   always_comb begin
      next_q = q;
      if (reset) begin
         next_q.flags = bank.por_value;
      end else begin
         next_q.flags = (q.flags & ~{8{bank.clear}}) | bank.set;
      end
   end

   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         q <= next_q;
      end
   end

   assign bank.flags = q.flags;

   set_wins_a: assert property (@(posedge core_clk)
      disable iff (reset) (clk_en && (bank.set != 8'h00)) |=>
      ((q.flags & $past(bank.set)) == $past(bank.set)))
      else $error("new event lost in flag bank");

   flag_hold_a: assert property (@(posedge core_clk)
      disable iff (reset) (clk_en && !bank.clear) |=>
      ((q.flags & $past(q.flags)) == $past(q.flags)))
      else $error("flag dropped without a clear");
endmodule

// ===== poe_port_event_interrupt_logic.sv
// Port event flags, interrupt gating and serial management slave
// Function
// - Detect summary is OR of four ports
// - Unplug summary is OR of four ports
// - Power-good summary is OR of ports
// - Power-on summary is OR of ports
// - Stop condition returns register pointer to zero
// - Mask bit gates matching summary onto interrupt
// - Flags update regardless of mask contents
// - Global enable needed for any interrupt
// - Mask reset: supply set, strap bits, rest zero
// - Mask bits map supply down to power-on
// - Power flags at 02h, clearing read 03h
// - Clearing read releases interrupt it caused
// - Probe flags at 04h, clearing read 05h
// - Fault flags at 06h, clearing read 07h
// - Start flags at 08h/09h, upper bits zero
// - Every event bit feeds its summary bit
// - Supply flags at 0Ah, clearing read 0Bh
// - Supply flags power up with logic-undervolt and sine bits set, port-undervolt too if late
// - Interrupt low when flagged, masked in, enabled
// - Clearing read empties its own group, clear-all empties summary
// - Supply, start, overcurrent, class summaries are ORs
`timescale 1ns/100ps
module poe_port_event_interrupt_logic (
   input wire logic core_clk,                  // Core clock, 25 MHz
   input wire logic reset,                     // Synchronous reset, high
   input wire logic clk_en,                    // Freezes all state when low
   input wire logic scl_pin,                   // Management bus clock pin
   input wire logic sda_in,                    // Management bus data level
   output logic sda_out,                       // Data drive value, always 0
   output logic sda_oe,                        // High while pulling data low
   input wire logic [3:0] slave_addr_pins,     // Low bits of slave address
   input wire logic mode_strap,                // Mode strap pin
   input wire logic port_supply_late,          // Port supply rose last
   input wire logic irq_global_enable,         // Global interrupt enable
   input wire logic clear_all_events,          // Pulse, clears every flag
   input wire logic [3:0] port_power_good_change,   // Event pulses
   input wire logic [3:0] port_power_on_change,     // Event pulses
   input wire logic [3:0] port_class_cycle,         // Event pulses
   input wire logic [3:0] port_detect_cycle,        // Event pulses
   input wire logic [3:0] port_unplug,              // Event pulses
   input wire logic [3:0] port_overcurrent_timeout, // Event pulses
   input wire logic [3:0] port_start_timeout,       // Event pulses
   input wire logic thermal_shutdown_flag,     // Supply event pulse
   input wire logic logic_supply_undervolt,    // Supply event pulse
   input wire logic port_supply_undervolt,     // Supply event pulse
   input wire logic sine_generator_fault,      // Supply event pulse
   output logic irq_n                          // Interrupt, active low
);
   typedef enum logic [8:0] {
      S_IDLE = 9'h001,
      S_ADDR = 9'h002,
      S_ADDR_ACK = 9'h004,
      S_PTR = 9'h008,
      S_PTR_ACK = 9'h010,
      S_WDATA = 9'h020,
      S_WACK = 9'h040,
      S_RDATA = 9'h080,
      S_RACK = 9'h100
   } link_state_e;

   typedef struct packed {
      link_state_e state;
      logic scl_prev;
      logic sda_prev;
      logic [7:0] shift;
      logic [3:0] count;
      logic [7:0] pointer;
      logic master_ack;
      logic drive_low;
      logic [7:0] mask;
      logic irq_n;
   } state_s;

   state_s q;
   state_s next_q;

   logic [7:0] pins_q;
   logic scl;
   logic sda;
   logic [3:0] addr_bits;
   logic strap;
   logic supply_late;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic fetch;
   logic write_strobe;
   logic [7:0] read_data;
   logic [7:0] summary;
   logic [4:0][7:0] group_set;
   logic [4:0] group_clear;
   logic [4:0][7:0] group_por;
   logic [4:0][7:0] group_flags;

   // Pin synchronisers
   pin_sync #(.WIDTH(8)) u_sync (
      .core_clk(core_clk),
      .clk_en(clk_en),
      .d({scl_pin, sda_in, slave_addr_pins, mode_strap, port_supply_late}),
      .q(pins_q)
   );

   assign scl = pins_q[7];
   assign sda = pins_q[6];
   assign addr_bits = pins_q[5:2];
   assign strap = pins_q[1];
   assign supply_late = pins_q[0];

   // Bus conditions from synchronised levels
   assign scl_rise = scl && !q.scl_prev;
   assign scl_fall = !scl && q.scl_prev;
   assign start_cond = scl && q.scl_prev && q.sda_prev && !sda;
   assign stop_cond = scl && q.scl_prev && !q.sda_prev && sda;

   // Byte fetch for a read, and byte write strobe
   assign fetch = !reset && scl_fall &&
      ((q.state == S_ADDR_ACK && q.shift[0]) ||
       (q.state == S_RACK && q.master_ack));
   assign write_strobe = !reset && scl_fall && q.state == S_WDATA &&
      q.count == poe_irq_pkg::BYTE_FULL;

   // Event inputs into the flag banks, one process drives the whole array
   always_comb begin
      group_set = '0;
      group_set[poe_irq_pkg::G_POWER] =
         {port_power_good_change, port_power_on_change};
      group_set[poe_irq_pkg::G_PROBE] =
         {port_class_cycle, port_detect_cycle};
      group_set[poe_irq_pkg::G_FAULT] =
         {port_unplug, port_overcurrent_timeout};
      group_set[poe_irq_pkg::G_START] = {4'h0, port_start_timeout};
      group_set[poe_irq_pkg::G_SUPPLY][poe_irq_pkg::SUP_THERMAL] =
         thermal_shutdown_flag;
      group_set[poe_irq_pkg::G_SUPPLY][poe_irq_pkg::SUP_LOGIC_UV] =
         logic_supply_undervolt;
      group_set[poe_irq_pkg::G_SUPPLY][poe_irq_pkg::SUP_PORT_UV] =
         port_supply_undervolt;
      group_set[poe_irq_pkg::G_SUPPLY][poe_irq_pkg::SUP_SINE] =
         sine_generator_fault;
   end

   // Power-on values of the flag banks
   always_comb begin
      group_por = '0;
      group_por[poe_irq_pkg::G_SUPPLY] = poe_irq_pkg::SUPPLY_POR_BASE |
         (supply_late ? poe_irq_pkg::SUPPLY_POR_LATE
                      : poe_irq_pkg::FLAGS_RESET);
   end

   // Flag banks, cleared by their clearing read or clear-all
   flag_bank_if #(.WIDTH(8)) grp [poe_irq_pkg::NUM_GROUPS] ();
   generate
      for (genvar g = 0; g < poe_irq_pkg::NUM_GROUPS; g++) begin : gen_bank
         assign group_clear[g] = (fetch &&
            q.pointer == poe_irq_pkg::CLEAR_ADDR[g]) ||
            clear_all_events;
         assign grp[g].set = group_set[g];
         assign grp[g].clear = group_clear[g];
         assign grp[g].por_value = group_por[g];
         assign group_flags[g] = grp[g].flags;
         sticky_flags u_bank (
            .core_clk(core_clk),
            .reset(reset),
            .clk_en(clk_en),
            .bank(grp[g])
         );
      end
   endgenerate

   // Summary bits, supply down to power-on
   always_comb begin
      summary = 8'h00;
      summary[poe_irq_pkg::BIT_SUPPLY] =
         |group_flags[poe_irq_pkg::G_SUPPLY];
      summary[poe_irq_pkg::BIT_START] =
         |group_flags[poe_irq_pkg::G_START][3:0];
      summary[poe_irq_pkg::BIT_OVERCURRENT] =
         |group_flags[poe_irq_pkg::G_FAULT][3:0];
      summary[poe_irq_pkg::BIT_CLASS] =
         |group_flags[poe_irq_pkg::G_PROBE][7:4];
      summary[poe_irq_pkg::BIT_DETECT] =
         |group_flags[poe_irq_pkg::G_PROBE][3:0];
      summary[poe_irq_pkg::BIT_UNPLUG] =
         |group_flags[poe_irq_pkg::G_FAULT][7:4];
      summary[poe_irq_pkg::BIT_POWER_GOOD] =
         |group_flags[poe_irq_pkg::G_POWER][7:4];
      summary[poe_irq_pkg::BIT_POWER_ON] =
         |group_flags[poe_irq_pkg::G_POWER][3:0];
   end

   // Register read selection, both addresses of a group alike
   always_comb begin
      case (q.pointer)
         poe_irq_pkg::ADDR_IRQ_SUMMARY: read_data = summary;
         poe_irq_pkg::ADDR_GATE_MASK: read_data = q.mask;
         poe_irq_pkg::ADDR_POWER,
         poe_irq_pkg::ADDR_POWER_CLR:
            read_data = group_flags[poe_irq_pkg::G_POWER];
         poe_irq_pkg::ADDR_PROBE,
         poe_irq_pkg::ADDR_PROBE_CLR:
            read_data = group_flags[poe_irq_pkg::G_PROBE];
         poe_irq_pkg::ADDR_FAULT,
         poe_irq_pkg::ADDR_FAULT_CLR:
            read_data = group_flags[poe_irq_pkg::G_FAULT];
         poe_irq_pkg::ADDR_START,
         poe_irq_pkg::ADDR_START_CLR:
            read_data = group_flags[poe_irq_pkg::G_START];
         poe_irq_pkg::ADDR_SUPPLY,
         poe_irq_pkg::ADDR_SUPPLY_CLR:
            read_data = group_flags[poe_irq_pkg::G_SUPPLY];
         default: read_data = 8'h00;
      endcase
   end

   // Link state machine, mask register and interrupt output
   always_comb begin
      next_q = q;
      next_q.scl_prev = scl;
      next_q.sda_prev = sda;
      if (reset) begin
         next_q.state = S_IDLE;
         next_q.scl_prev = 1'b1;
         next_q.sda_prev = 1'b1;
         next_q.shift = 8'h00;
         next_q.count = 4'h0;
         next_q.pointer = poe_irq_pkg::POINTER_RESET;
         next_q.master_ack = 1'b0;
         next_q.drive_low = 1'b0;
         next_q.mask = poe_irq_pkg::MASK_RESET_FIXED |
            (strap ? poe_irq_pkg::MASK_STRAP_BITS
                   : poe_irq_pkg::FLAGS_RESET);
         next_q.irq_n = 1'b1;
      end else begin
         if (stop_cond) begin
            next_q.state = S_IDLE;
            next_q.drive_low = 1'b0;
            next_q.pointer = poe_irq_pkg::POINTER_RESET;
         end else if (start_cond) begin
            next_q.state = S_ADDR;
            next_q.count = 4'h0;
            next_q.drive_low = 1'b0;
         end else begin
            unique case (q.state)
               S_IDLE: begin
                  next_q.drive_low = 1'b0;
               end
               S_ADDR, S_PTR, S_WDATA: begin
                  if (scl_rise) begin
                     next_q.shift = {q.shift[6:0], sda};
                     next_q.count = q.count + 4'h1;
                  end else if (scl_fall &&
                               q.count == poe_irq_pkg::BYTE_FULL) begin
                     next_q.drive_low = 1'b1;
                     next_q.count = 4'h0;
                     if (q.state == S_ADDR) begin
                        if (q.shift[7:1] ==
                            {poe_irq_pkg::SLAVE_ADDR_HIGH, addr_bits}) begin
                           next_q.state = S_ADDR_ACK;
                        end else begin
                           next_q.state = S_IDLE;
                           next_q.drive_low = 1'b0;
                        end
                     end else if (q.state == S_PTR) begin
                        next_q.pointer = q.shift;
                        next_q.state = S_PTR_ACK;
                     end else begin
                        if (write_strobe &&
                            q.pointer == poe_irq_pkg::ADDR_GATE_MASK) begin
                           next_q.mask = q.shift;
                        end
                        next_q.pointer = q.pointer + 8'h01;
                        next_q.state = S_WACK;
                     end
                  end
               end
               S_ADDR_ACK, S_PTR_ACK, S_WACK: begin
                  if (fetch) begin
                     next_q.shift = read_data;
                     next_q.drive_low = !read_data[7];
                     next_q.pointer = q.pointer + 8'h01;
                     next_q.state = S_RDATA;
                  end else if (scl_fall) begin
                     next_q.drive_low = 1'b0;
                     next_q.state = (q.state == S_ADDR_ACK) ? S_PTR : S_WDATA;
                  end
               end
               S_RDATA: begin
                  if (scl_fall) begin
                     if (q.count == poe_irq_pkg::TX_LAST_BIT) begin
                        next_q.drive_low = 1'b0;
                        next_q.state = S_RACK;
                     end else begin
                        next_q.shift = {q.shift[6:0], 1'b0};
                        next_q.drive_low = !q.shift[6];
                        next_q.count = q.count + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     next_q.master_ack = !sda;
                  end else if (fetch) begin
                     next_q.shift = read_data;
                     next_q.drive_low = !read_data[7];
                     next_q.count = 4'h0;
                     next_q.pointer = q.pointer + 8'h01;
                     next_q.state = S_RDATA;
                  end else if (scl_fall) begin
                     next_q.state = S_IDLE;
                  end
               end
            endcase
         end
         // Flags keep updating; only the output is gated
         next_q.irq_n = !((|(summary & q.mask)) &&
            irq_global_enable);
      end
   end

   always_ff @(posedge core_clk) begin
      if (clk_en) begin
         q <= next_q;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = q.drive_low;
   assign irq_n = q.irq_n;

   default clocking cb @(posedge core_clk); endclocking

   sequence power_clear_read;
      clk_en && !reset && fetch &&
      q.pointer == poe_irq_pkg::ADDR_POWER_CLR &&
      port_power_good_change == 4'h0 && port_power_on_change == 4'h0;
   endsequence

   sequence others_quiet;
      clk_en && !reset && !clear_all_events &&
      group_flags[4:1] == '0 && group_set == '0;
   endsequence

   detect_sum_a: assert property (disable iff (reset)
      (clk_en && port_detect_cycle != 4'h0) |=> summary[3])
      else $error("detect summary not set by port event");

   unplug_sum_a: assert property (disable iff (reset)
      (clk_en && port_unplug != 4'h0) |=> summary[2])
      else $error("unplug summary not set by port event");

   power_good_sum_a: assert property (disable iff (reset)
      (clk_en && port_power_good_change != 4'h0) |=> summary[1])
      else $error("power-good summary not set by port event");

   power_on_sum_a: assert property (disable iff (reset)
      (clk_en && port_power_on_change != 4'h0) |=> summary[0])
      else $error("power-on summary not set by port event");

   pointer_stop_a: assert property (disable iff (reset)
      (clk_en && stop_cond) |=> (q.pointer == 8'h00 && q.state == S_IDLE))
      else $error("pointer not returned after stop");

   irq_gate_a: assert property (disable iff (reset)
      $past(clk_en) && !$past(reset) |->
      irq_n == !($past(|(summary & q.mask)) && $past(irq_global_enable)))
      else $error("interrupt output not gated by mask and enable");

   unmasked_flag_a: assert property (disable iff (reset)
      (clk_en && port_start_timeout != 4'h0 && !q.mask[6]) |=> summary[6])
      else $error("start summary not updated while masked");

   mask_reset_a: assert property (disable iff (1'b0)
      (clk_en && reset) [*3] |=>
      q.mask == (8'h80 | ($past(strap) ? 8'h64 : 8'h00)))
      else $error("mask reset value wrong");

   supply_por_a: assert property (disable iff (1'b0)
      (clk_en && reset) [*3] |=>
      group_flags[4] == (8'h22 | ($past(supply_late) ? 8'h10 : 8'h00)))
      else $error("supply power-on flags wrong");

   power_clear_a: assert property (disable iff (reset)
      power_clear_read |=> group_flags[0] == 8'h00)
      else $error("clearing read left power flags set");

   irq_release_a: assert property (disable iff (reset)
      power_clear_read ##0 others_quiet ##1 others_quiet |=> irq_n)
      else $error("interrupt not released after clearing read");

   clear_all_a: assert property (disable iff (reset)
      (clk_en && clear_all_events && group_set == '0) |=> summary == 8'h00)
      else $error("clear-all left summary bits set");
endmodule

// ===== host_i2c.sv
// Management bus host model, bit-banged master on an open-drain line
`timescale 1ns/100ps
module host_i2c (
   output logic scl,       // Bus clock, idles high
   output logic sda_drv,   // Data drive, 1 releases the line
   input wire logic sda    // Resolved data line
);
   localparam time Q = 80ns;
   // Both lines released while idle
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Start, also usable as repeated start
   task automatic start();
      #Q sda_drv = 1'b1;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b0;
      #Q scl = 1'b0;
   endtask
   // Stop, pointer returns to zero after it
   task automatic stop();
      #Q sda_drv = 1'b0;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b1;
      #Q;
   endtask
   // One bit, data changed only while the clock is low
   task automatic bitx(input logic b, output logic r);
      #Q sda_drv = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
   endtask
   // Byte MSB first plus ninth bit
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bitx(d[i], r[i]);
      end
      bitx(last, ack);
   endtask
endmodule

// ===== poe_port_event_interrupt_logic_tb_top.sv
// Register-level bench for the port event and interrupt logic
`timescale 1ns/100ps
module poe_port_event_interrupt_logic_tb_top;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic en = 1'b1;
   logic clr_all = 1'b0;
   logic ce = 1'b1;
   logic strap = 1'b1;
   logic late = 1'b1;
   logic [6:0][3:0] ev = '0;
   logic [3:0] sup = 4'h0;
   logic scl, h_sda, sda_out, sda_oe, irq_n;
   wire sda = h_sda & (~sda_oe | sda_out);
   int n_errors = 0;
   int check_count = 0;
   localparam logic [7:0] GA[7] = '{8'h02, 8'h02, 8'h04, 8'h04, 8'h06,
                                    8'h06, 8'h08};
   localparam int FB[7] = '{4, 0, 4, 0, 4, 0, 0};
   localparam int SB[7] = '{1, 0, 4, 3, 2, 5, 6};
   always #20 core_clk = ~core_clk;
   host_i2c h (.scl(scl), .sda_drv(h_sda), .sda(sda));
   poe_port_event_interrupt_logic dut (.core_clk(core_clk),
      .reset(reset), .clk_en(ce), .scl_pin(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .slave_addr_pins(4'h5),
      .mode_strap(strap), .port_supply_late(late),
      .irq_global_enable(en), .clear_all_events(clr_all),
      .port_power_good_change(ev[0]), .port_power_on_change(ev[1]),
      .port_class_cycle(ev[2]), .port_detect_cycle(ev[3]),
      .port_unplug(ev[4]), .port_overcurrent_timeout(ev[5]),
      .port_start_timeout(ev[6]), .thermal_shutdown_flag(sup[3]),
      .logic_supply_undervolt(sup[2]), .port_supply_undervolt(sup[1]),
      .sine_generator_fault(sup[0]), .irq_n(irq_n));
   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Pointer write then register read; bare skips the pointer
   task automatic rd(input logic [7:0] a, input logic bare,
                     input logic [7:0] e);
      logic [7:0] x;
      logic k;
      h.start();
      if (!bare) begin
         h.xfer(8'h4A, 1'b1, x, k);
         h.xfer(a, 1'b1, x, k);
         h.start();
      end
      h.xfer(8'h4B, 1'b1, x, k);
      h.xfer(8'hFF, 1'b1, x, k);
      h.stop();
      chk(x, e);
   endtask
   // Register write of one data byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      logic k;
      h.start();
      h.xfer(8'h4A, 1'b1, x, k);
      h.xfer(a, 1'b1, x, k);
      h.xfer(d, 1'b1, x, k);
      h.stop();
   endtask
   // Pulse on negative edges, then let flag and pin settle
   task automatic pulse(input int g, input int p);
      @(negedge core_clk);
      if (g < 7) ev[g][p] = 1'b1;
      else sup = 4'hF;
      @(negedge core_clk);
      ev = '0;
      sup = 4'h0;
      repeat (3) @(negedge core_clk);
   endtask
   // Watchdog well above the expected run length
   initial begin
      #3ms;
      n_errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      logic [7:0] x;
      logic k;
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      rd(8'h01, 1'b0, 8'hE4);
      rd(8'h0A, 1'b0, 8'h32);
      rd(8'h00, 1'b1, 8'h80);
      chk({7'h0, irq_n}, 8'h00);
      rd(8'h0B, 1'b0, 8'h32);
      rd(8'h0A, 1'b0, 8'h00);
      wr(8'h01, 8'h00);
      for (int i = 0; i < 7; i++) begin
         pulse(i, i % 4);
         chk({7'h0, irq_n}, 8'h01);
         rd(8'h00, 1'b1, 8'h01 << SB[i]);
         wr(8'h01, 8'h01 << SB[i]);
         chk({7'h0, irq_n}, 8'h00);
         en = 1'b0; // Host withdraws global enable
         repeat (3) @(negedge core_clk);
         chk({7'h0, irq_n}, 8'h01);
         en = 1'b1;
         repeat (3) @(negedge core_clk);
         rd(GA[i] + 8'h01, 1'b0,
            8'h01 << (FB[i] + i % 4));
         chk({7'h0, irq_n}, 8'h01);
         rd(GA[i], 1'b0, 8'h00);
      end
      wr(8'h01, 8'h80);
      pulse(7, 0);
      chk({7'h0, irq_n}, 8'h00);
      // Burst read: plain supply byte, then its clearing address
      h.start();
      h.xfer(8'h4A, 1'b1, x, k);
      h.xfer(8'h0A, 1'b1, x, k);
      h.start();
      h.xfer(8'h4B, 1'b1, x, k);
      h.xfer(8'hFF, 1'b0, x, k);
      chk(x, 8'hB2);
      h.xfer(8'hFF, 1'b1, x, k);
      chk(x, 8'hB2);
      h.stop();
      chk({7'h0, irq_n}, 8'h01);
      @(negedge core_clk);
      clr_all = 1'b1;
      @(negedge core_clk);
      clr_all = 1'b0;
      rd(8'h00, 1'b1, 8'h00);
      // Frozen core takes no event
      ce = 1'b0;
      pulse(3, 1);
      ce = 1'b1;
      rd(8'h00, 1'b1, 8'h00);
      // Second reset with both straps low
      strap = 1'b0;
      late = 1'b0;
      reset = 1'b1;
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      rd(8'h01, 1'b0, 8'h80);
      rd(8'h0A, 1'b0, 8'h22);
      wrap_up();
   end
endmodule
